/* dma_channel_pkg.sv */
// constants, types and register map of the dma channel control block
package dma_channel_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_SOURCE = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // control register bit positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_TEND = 1;
  localparam int BIT_IRQ_EN = 2;
  localparam int BIT_SIZE_LO = 3;
  localparam int BIT_BUS_MODE = 5;
  localparam int BIT_SENSE = 6;
  localparam int BIT_REQ_LO = 8;
  localparam int BIT_SRC_LO = 12;
  localparam int BIT_DST_LO = 14;
  localparam int BIT_ACK_LEVEL = 16;
  localparam int BIT_ACK_MODE = 17;
  localparam int BIT_REQ_LEVEL = 18;
  localparam int BIT_RELOAD = 19;
  localparam int BIT_INDIRECT = 20;

  // writable bits: common to all channels, then per-channel extras
  localparam logic [31:0] MASK_COMMON = 32'h0000_FF3D;
  localparam logic [31:0] MASK_CH01 = 32'h0007_0040;
  localparam logic [31:0] MASK_CH2 = 32'h0008_0000;
  localparam logic [31:0] MASK_CH3 = 32'h0010_0000;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

  // source stepping modes
  localparam logic [1:0] STEP_HOLD = 2'b00;
  localparam logic [1:0] STEP_INC = 2'b01;
  localparam logic [1:0] STEP_DEC = 2'b10;

  // transfer unit sizes
  localparam logic [1:0] SIZE_BYTE = 2'b00;
  localparam logic [1:0] SIZE_WORD = 2'b01;
  localparam logic [1:0] SIZE_LONG = 2'b10;
  localparam logic [1:0] SIZE_BLOCK = 2'b11;

  // request source codes
  localparam logic [3:0] REQ_EXT_DUAL = 4'h0;
  localparam logic [3:0] REQ_EXT_TO_DEV = 4'h2;
  localparam logic [3:0] REQ_EXT_FROM_DEV = 4'h3;
  localparam logic [3:0] REQ_AUTO = 4'h4;
  localparam logic [3:0] REQ_PERIPH_FIRST = 4'hA;
  localparam int PERIPH_COUNT = 6;

  // address stepping figures
  localparam logic [31:0] STEP_POINTER = 32'h0000_0004;
  localparam logic [31:0] STEP_BLOCK = 32'h0000_0010;
  localparam logic [1:0] BLOCK_LAST_BEAT = 2'h3;
  localparam logic [31:0] COUNT_LAST = 32'h0000_0001;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_MOVE = 2'b10,
    ST_STEP = 2'b11
  } chan_state_e;

  // one bus cycle request towards the transfer sequencer
  typedef struct packed {
    logic fetch;
    logic [1:0] size;
    logic [31:0] addr;
  } xfer_cmd_s;

endpackage

/* dma_channel_control.sv */
// control logic of one dma channel: registers, request sensing, stepping, end flag
//
// Functional notes
// - source address stepped per unit by mode
// - hold, increment, decrement; prohibited code holds
// - channel three offers indirect addressing mode
// - indirect: fetch real address through pointer first
// - indirect pointer steps by four regardless size
// - external dual, single both ways, auto codes
// - six peripheral request codes decoded
// - external requests only on channels zero, one
// - sense bit: low level or falling edge
// - peripheral uses falling edge; auto ignores sense
// - bus mode: cycle steal or burst
// - unit size byte, word, long, block
// - count decrements per unit, ends at zero
// - end flag set after programmed count
// - irq enable gates completion interrupt request
// - early stop leaves end flag clear
// - flag cleared by zero after read, reset
// - auto starts on enable; others need request
// - clearing enable terminates running transfer
// - transfer needs enable, master, no flag, nmi
// - channel enable resets to zero
// - ack controls only on channels zero, one
`timescale 1ns/1ps
module dma_channel_control #(
  parameter int CHANNEL_ID = 0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata_q,
  // global controls
  input wire logic master_enable,
  input wire logic nmi_flag,
  input wire logic addr_error,
  // request sources
  input wire logic transfer_request_pin_n,
  input wire logic [5:0] periph_req_n,
  output logic transfer_acknowledge_pin_q,
  // sequencer side
  output logic xfer_valid_q,
  output dma_channel_pkg::xfer_cmd_s xfer_cmd_q,
  input wire logic xfer_done,
  input wire logic [31:0] xfer_rdata,
  // interrupt
  output logic end_interrupt_q
);

  ////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [31:0] unit_bytes(input logic [1:0] size);
    unit_bytes = 32'h0000_0001;
    case (size)
      dma_channel_pkg::SIZE_BYTE: unit_bytes = 32'h0000_0001;
      dma_channel_pkg::SIZE_WORD: unit_bytes = 32'h0000_0002;
      dma_channel_pkg::SIZE_LONG: unit_bytes = 32'h0000_0004;
      dma_channel_pkg::SIZE_BLOCK: unit_bytes = dma_channel_pkg::STEP_BLOCK;
      default: unit_bytes = 32'h0000_0001;
    endcase
  endfunction

  // next source address after one unit
  function automatic logic [31:0] step_addr(input logic [31:0] addr, input logic [1:0] mode,
                                            input logic [1:0] size, input logic indirect);
    logic [31:0] delta;
    delta = indirect ? dma_channel_pkg::STEP_POINTER : unit_bytes(size);
    step_addr = addr;
    case (mode)
      dma_channel_pkg::STEP_HOLD: step_addr = addr;
      dma_channel_pkg::STEP_INC: step_addr = addr + delta;
      dma_channel_pkg::STEP_DEC: begin
        // decrement is illegal for block units outside indirect mode: hold instead
        if (indirect || size != dma_channel_pkg::SIZE_BLOCK) begin
          step_addr = addr - delta;
        end
      end
      default: step_addr = addr;
    endcase
  endfunction

  function automatic logic is_periph(input logic [3:0] code);
    is_periph = (code >= dma_channel_pkg::REQ_PERIPH_FIRST);
  endfunction

  function automatic logic is_external(input logic [3:0] code);
    is_external = (code == dma_channel_pkg::REQ_EXT_DUAL) ||
                  (code == dma_channel_pkg::REQ_EXT_TO_DEV) ||
                  (code == dma_channel_pkg::REQ_EXT_FROM_DEV);
  endfunction

  function automatic logic [31:0] write_mask(input int ch);
    write_mask = dma_channel_pkg::MASK_COMMON;
    if (ch < 2) begin
      write_mask = write_mask | dma_channel_pkg::MASK_CH01;
    end else if (ch == 2) begin
      write_mask = write_mask | dma_channel_pkg::MASK_CH2;
    end else begin
      write_mask = write_mask | dma_channel_pkg::MASK_CH3;
    end
    // the end flag has its own register
    write_mask[dma_channel_pkg::BIT_TEND] = 1'b0;
  endfunction

  localparam logic [31:0] CTRL_MASK = write_mask(CHANNEL_ID);
  localparam logic EXT_ALLOWED = (CHANNEL_ID < 2);
  localparam logic [31:0] COUNT_ONE = dma_channel_pkg::COUNT_LAST;

  ////////////////////////////////////////////////////////////////////
  // declarations

  logic [31:0] ctrl_q;
  logic tend_q;
  logic tend_seen_q;
  logic [31:0] src_q;
  logic [31:0] count_q;
  logic [31:0] data_addr_q;
  dma_channel_pkg::chan_state_e state_q;
  logic [1:0] beat_q;
  logic burst_q;
  logic req_meta_q;
  logic req_sync_q;
  logic req_prev_q;
  logic [5:0] periph_prev_q;
  logic edge_seen_q;

  logic ch_enable;
  logic [1:0] size_sel;
  logic [1:0] src_mode;
  logic [3:0] req_code;
  logic sense_edge;
  logic burst_sel;
  logic indirect;
  logic ack_level;
  logic permit;
  logic ext_sel;
  logic periph_sel;
  logic auto_sel;
  logic [2:0] periph_idx;
  logic edge_now;
  logic pending;
  logic start;
  logic unit_done;
  logic last_unit;
  logic ctrl_wr;
  logic tend_set;
  logic [31:0] ctrl_view;

  ////////////////////////////////////////////////////////////////////
  // decode of control fields

  assign ch_enable = ctrl_q[dma_channel_pkg::BIT_ENABLE];
  assign size_sel = ctrl_q[dma_channel_pkg::BIT_SIZE_LO +: 2];
  assign src_mode = ctrl_q[dma_channel_pkg::BIT_SRC_LO +: 2];
  assign req_code = ctrl_q[dma_channel_pkg::BIT_REQ_LO +: 4];
  assign sense_edge = ctrl_q[dma_channel_pkg::BIT_SENSE];
  assign burst_sel = ctrl_q[dma_channel_pkg::BIT_BUS_MODE];
  assign indirect = ctrl_q[dma_channel_pkg::BIT_INDIRECT];
  assign ack_level = ctrl_q[dma_channel_pkg::BIT_ACK_LEVEL];
  assign ctrl_view = ctrl_q | ({31'h0000_0000, tend_q} << dma_channel_pkg::BIT_TEND);

  assign permit = ch_enable && !tend_q && master_enable && !nmi_flag && !addr_error;
  assign ext_sel = EXT_ALLOWED && is_external(req_code);
  assign periph_sel = is_periph(req_code);
  assign auto_sel = (req_code == dma_channel_pkg::REQ_AUTO);
  assign periph_idx = 3'(req_code - dma_channel_pkg::REQ_PERIPH_FIRST);
  assign ctrl_wr = reg_write && (reg_addr == dma_channel_pkg::OFS_CONTROL);

  ////////////////////////////////////////////////////////////////////
  // request sensing

  // request pin comes from outside: two flops before use
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      req_meta_q <= 1'b1;
      req_sync_q <= 1'b1;
      req_prev_q <= 1'b1;
    end else begin
      req_meta_q <= transfer_request_pin_n;
      req_sync_q <= req_meta_q;
      req_prev_q <= req_sync_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      periph_prev_q <= 6'h3F;
    end else begin
      periph_prev_q <= periph_req_n;
    end
  end

  always_comb begin
    edge_now = 1'b0;
    if (ext_sel) begin
      edge_now = req_prev_q && !req_sync_q;
    end else if (periph_sel && periph_idx < 3'(dma_channel_pkg::PERIPH_COUNT)) begin
      edge_now = periph_prev_q[periph_idx] && !periph_req_n[periph_idx];
    end
  end

  // edges only count once the channel is enabled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      edge_seen_q <= 1'b0;
    end else if (ch_enable && edge_now) begin
      edge_seen_q <= 1'b1;
    end else if (!ch_enable || start) begin
      edge_seen_q <= 1'b0;
    end
  end

  always_comb begin
    pending = 1'b0;
    if (auto_sel) begin
      pending = 1'b1;
    end else if (ext_sel) begin
      pending = sense_edge ? edge_seen_q : !req_sync_q;
    end else if (periph_sel) begin
      pending = edge_seen_q;
    end
  end

  assign start = (state_q == dma_channel_pkg::ST_IDLE) && permit && pending;
  assign unit_done = (state_q == dma_channel_pkg::ST_MOVE) && xfer_done &&
                     (size_sel != dma_channel_pkg::SIZE_BLOCK ||
                      beat_q == dma_channel_pkg::BLOCK_LAST_BEAT);
  assign last_unit = (count_q == dma_channel_pkg::COUNT_LAST);
  assign tend_set = unit_done && last_unit && permit;

  ////////////////////////////////////////////////////////////////////
  // channel sequencer

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= dma_channel_pkg::ST_IDLE;
    end else if (!permit) begin
      state_q <= dma_channel_pkg::ST_IDLE;
    end else begin
      case (state_q)
        dma_channel_pkg::ST_IDLE: begin
          if (start) begin
            state_q <= indirect ? dma_channel_pkg::ST_FETCH : dma_channel_pkg::ST_MOVE;
          end
        end
        dma_channel_pkg::ST_FETCH: begin
          if (xfer_done) begin
            state_q <= dma_channel_pkg::ST_MOVE;
          end
        end
        dma_channel_pkg::ST_MOVE: begin
          if (unit_done) begin
            state_q <= dma_channel_pkg::ST_STEP;
          end
        end
        dma_channel_pkg::ST_STEP: begin
          if (tend_q || !burst_q) begin
            state_q <= dma_channel_pkg::ST_IDLE;
          end else begin
            state_q <= indirect ? dma_channel_pkg::ST_FETCH : dma_channel_pkg::ST_MOVE;
          end
        end
        default: state_q <= dma_channel_pkg::ST_IDLE;
      endcase
    end
  end

  // burst keeps running once started; cycle steal needs a request per unit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      burst_q <= 1'b0;
    end else if (start) begin
      burst_q <= burst_sel;
    end else if (!permit) begin
      burst_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      beat_q <= 2'h0;
    end else if (state_q != dma_channel_pkg::ST_MOVE) begin
      beat_q <= 2'h0;
    end else if (xfer_done) begin
      beat_q <= beat_q + 2'h1;
    end
  end

  // fetched data address in indirect mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_addr_q <= dma_channel_pkg::RESET_ZERO;
    end else if (state_q == dma_channel_pkg::ST_FETCH && xfer_done) begin
      data_addr_q <= xfer_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer requests and pins

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xfer_valid_q <= 1'b0;
      xfer_cmd_q <= '0;
    end else begin
      xfer_valid_q <= permit && !xfer_done &&
                      (state_q == dma_channel_pkg::ST_FETCH ||
                       state_q == dma_channel_pkg::ST_MOVE);
      xfer_cmd_q.fetch <= (state_q == dma_channel_pkg::ST_FETCH);
      xfer_cmd_q.size <= (size_sel == dma_channel_pkg::SIZE_BLOCK) ?
                         dma_channel_pkg::SIZE_LONG : size_sel;
      if (state_q == dma_channel_pkg::ST_FETCH) begin
        xfer_cmd_q.addr <= src_q;
      end else begin
        xfer_cmd_q.addr <= (indirect ? data_addr_q : src_q) +
                           (32'(beat_q) * dma_channel_pkg::STEP_POINTER);
      end
    end
  end

  // acknowledge driven at the selected level while an external unit moves
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      transfer_acknowledge_pin_q <= 1'b1;
    end else if (ext_sel && state_q == dma_channel_pkg::ST_MOVE && permit) begin
      transfer_acknowledge_pin_q <= ack_level;
    end else begin
      transfer_acknowledge_pin_q <= !ack_level;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= dma_channel_pkg::RESET_ZERO;
    end else if (ctrl_wr) begin
      ctrl_q <= reg_wdata & CTRL_MASK;
    end
  end

  // source address, or pointer in indirect mode; hardware step wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      src_q <= dma_channel_pkg::RESET_ZERO;
    end else if (unit_done && permit) begin
      src_q <= step_addr(src_q, src_mode, size_sel, indirect);
    end else if (reg_write && reg_addr == dma_channel_pkg::OFS_SOURCE) begin
      src_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= dma_channel_pkg::RESET_ZERO;
    end else if (unit_done && permit) begin
      count_q <= count_q - COUNT_ONE;
    end else if (reg_write && reg_addr == dma_channel_pkg::OFS_COUNT) begin
      count_q <= reg_wdata;
    end
  end

  // clear armed by a read that saw the flag set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tend_seen_q <= 1'b0;
    end else if (reg_read && reg_addr == dma_channel_pkg::OFS_CONTROL && tend_q) begin
      tend_seen_q <= 1'b1;
    end else if (ctrl_wr || !tend_q) begin
      tend_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tend_q <= 1'b0;
    end else if (tend_set) begin
      tend_q <= 1'b1;
    end else if (ctrl_wr && tend_seen_q && !reg_wdata[dma_channel_pkg::BIT_TEND]) begin
      tend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      end_interrupt_q <= 1'b0;
    end else begin
      end_interrupt_q <= tend_q && ctrl_q[dma_channel_pkg::BIT_IRQ_EN];
    end
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= dma_channel_pkg::RESET_ZERO;
    end else if (reg_read) begin
      case (reg_addr)
        dma_channel_pkg::OFS_CONTROL: reg_rdata_q <= ctrl_view;
        dma_channel_pkg::OFS_SOURCE: reg_rdata_q <= src_q;
        dma_channel_pkg::OFS_COUNT: reg_rdata_q <= count_q;
        dma_channel_pkg::OFS_STATUS: reg_rdata_q <= {27'h000_0000, permit, pending,
                                                     burst_q, state_q};
        default: reg_rdata_q <= dma_channel_pkg::RESET_ZERO;
      endcase
    end else begin
      reg_rdata_q <= dma_channel_pkg::RESET_ZERO;
    end
  end

endmodule

/* dma_channel_control_fix.sv */
// note: none

/* dma_channel_checker_assertions.sv */
// port-level checker of the dma channel control block
`timescale 1ns/1ps
module dma_channel_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata_q,
  // global controls
  input wire logic master_enable,
  input wire logic nmi_flag,
  input wire logic addr_error,
  // sequencer side and interrupt
  input wire logic xfer_valid_q,
  input wire dma_channel_pkg::xfer_cmd_s xfer_cmd_q,
  input wire logic xfer_done,
  input wire logic end_interrupt_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_rdata_idle: assert property (!reg_read |=> reg_rdata_q == 32'h0)
    else $error("read data not zero outside a read answer");
  a_beat_hold: assert property (xfer_valid_q && !xfer_done && master_enable &&
    !nmi_flag && !addr_error && !$past(reg_write) |=>
    xfer_valid_q && $stable(xfer_cmd_q))
    else $error("beat request dropped or changed before done");
  a_beat_drop: assert property (xfer_valid_q && xfer_done |=> !xfer_valid_q)
    else $error("beat request held after done");
  a_irq_level: assert property ($past(reg_read) &&
    $past(reg_addr) == dma_channel_pkg::OFS_CONTROL |->
    end_interrupt_q == (reg_rdata_q[dma_channel_pkg::BIT_TEND] &&
    reg_rdata_q[dma_channel_pkg::BIT_IRQ_EN]))
    else $error("interrupt level differs from flag and enable");
  a_disable_stop: assert property (reg_write &&
    reg_addr == dma_channel_pkg::OFS_CONTROL &&
    !reg_wdata[dma_channel_pkg::BIT_ENABLE] |-> ##[1:2] !xfer_valid_q)
    else $error("transfer runs on after channel disable");
  a_master_off: assert property ((!master_enable) [*2] |=> !xfer_valid_q)
    else $error("transfer while master enable low");
  a_nmi_off: assert property (nmi_flag [*2] |=> !xfer_valid_q)
    else $error("transfer while nmi flag high");
  a_error_off: assert property (addr_error [*2] |=> !xfer_valid_q)
    else $error("transfer while address error high");

  c_beat: cover property (xfer_valid_q && xfer_done);
  c_irq: cover property ($rose(end_interrupt_q));
  c_abort: cover property (xfer_valid_q && !master_enable);
endmodule

bind dma_channel_control dma_channel_checker u_dma_channel_checker (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
  .master_enable(master_enable), .nmi_flag(nmi_flag), .addr_error(addr_error),
  .xfer_valid_q(xfer_valid_q), .xfer_cmd_q(xfer_cmd_q), .xfer_done(xfer_done),
  .end_interrupt_q(end_interrupt_q)
);

/* seq_model.sv */
// sequencer model: answers each beat after a set delay
`timescale 1ns/1ps
module seq_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // beat handshake
  input wire logic xfer_valid_q,
  input wire logic [3:0] lat,
  input wire logic [31:0] ptr,
  output logic xfer_done,
  output logic [31:0] xfer_rdata
);
  logic [3:0] cnt_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 4'h0;
      xfer_done <= 1'b0;
      xfer_rdata <= 32'h0;
    end else begin
      // data line changes every cycle outside the answer
      xfer_rdata <= ~xfer_rdata;
      xfer_done <= 1'b0;
      if (xfer_done || !xfer_valid_q) begin
        cnt_q <= 4'h0;
      end else if (cnt_q == lat) begin
        xfer_done <= 1'b1;
        xfer_rdata <= ptr;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

/* dma_channel_control_tb.sv */
// self-checking bench of the dma channel control block
`timescale 1ns/1ps
`define P(n) dma_channel_pkg::n
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t got %0h want %0h", $time, a, b); end end
module dma_channel_control_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata_q;
  logic master_enable = 1'b1;
  logic nmi_flag = 1'b0;
  logic addr_error = 1'b0;
  logic pin_n = 1'b1;
  logic [5:0] periph_req_n = 6'h3F;
  logic xfer_valid_q;
  dma_channel_pkg::xfer_cmd_s xfer_cmd_q;
  logic xfer_done;
  logic [31:0] xfer_rdata;
  logic end_interrupt_q;
  logic ack_pin;
  logic ack_seen = 1'b1;
  logic [1:0] size_seen = 2'h0;
  logic [3:0] lat = 4'h1;
  logic [31:0] beats[$];
  logic [31:0] v;
  logic [1:0] sz_t[10] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h2};
  logic [1:0] st_t[10] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h0, 2'h2, 2'h3};
  int dl_t[10] = '{1, 2, 4, 16, -1, -2, -4, 0, 0, 0};
  int err_count = 0;
  int checked = 0;

  always #12.5 clk = ~clk;

  dma_channel_control #(.CHANNEL_ID(0)) u_dma_channel_control (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
    .master_enable(master_enable), .nmi_flag(nmi_flag), .addr_error(addr_error),
    .transfer_request_pin_n(pin_n), .periph_req_n(periph_req_n),
    .transfer_acknowledge_pin_q(ack_pin), .xfer_valid_q(xfer_valid_q),
    .xfer_cmd_q(xfer_cmd_q), .xfer_done(xfer_done), .xfer_rdata(xfer_rdata),
    .end_interrupt_q(end_interrupt_q));

  seq_model u_seq_model (.clk(clk), .reset(reset), .xfer_valid_q(xfer_valid_q),
    .lat(lat), .ptr(32'h0000_2000), .xfer_done(xfer_done), .xfer_rdata(xfer_rdata));

  // log of completed beat addresses
  always @(posedge clk) begin
    if (xfer_valid_q === 1'b1 && xfer_done === 1'b1) begin
      beats.push_back(xfer_cmd_q.addr);
      ack_seen <= ack_pin;
      size_seen <= xfer_cmd_q.size;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata_q;
  endtask

  function automatic logic [31:0] ctl(input logic [3:0] req, input logic [1:0] sz,
                                      input logic [1:0] st, input logic ien);
    ctl = {18'h0, st, req, 3'h0, sz, ien, 1'b0, 1'b1};
  endfunction

  task automatic wait_tend(output logic [31:0] d);
    int n = 0;
    d = 32'h0;
    while (d[1] !== 1'b1 && n < 100) begin
      rd(`P(OFS_CONTROL), d);
      n++;
    end
    `CHK(d[1], 1'b1)
    if (d[1] !== 1'b1) print_verdict();
  endtask

  task automatic wait_valid();
    int n = 0;
    while (xfer_valid_q !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    `CHK(xfer_valid_q, 1'b1)
    if (xfer_valid_q !== 1'b1) print_verdict();
  endtask

  // clears flag after it was read as one
  task automatic clear();
    logic [31:0] d;
    wr(`P(OFS_CONTROL), 32'h0);
    rd(`P(OFS_CONTROL), d);
    `CHK(d, 32'h0)
    `CHK(end_interrupt_q, 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(`P(OFS_CONTROL), v);
    `CHK(v, 32'h0)
    rd(8'h10, v);
    `CHK(v, 32'h0)
    rd(`P(OFS_STATUS), v);
    `CHK(v, 32'h0)
    `CHK(ack_pin, 1'b1)
    wr(`P(OFS_CONTROL), 32'h0000_0002);
    rd(`P(OFS_CONTROL), v);
    `CHK(v, 32'h0)
    wr(`P(OFS_CONTROL), 32'hFFFF_FFFE);
    rd(`P(OFS_CONTROL), v);
    `CHK(v, 32'hFFFF_FFFE & (`P(MASK_COMMON) | `P(MASK_CH01)))
    wr(`P(OFS_CONTROL), 32'h0);
    // sizes and stepping modes, two units each
    for (int i = 0; i < 10; i++) begin
      beats.delete();
      wr(`P(OFS_SOURCE), 32'h0000_1000);
      wr(`P(OFS_COUNT), 32'h0000_0002);
      wr(`P(OFS_CONTROL), ctl(`P(REQ_AUTO), sz_t[i], st_t[i], i[0]));
      wait_tend(v);
      `CHK(beats.size(), (sz_t[i] == 2'h3) ? 8 : 2)
      `CHK(beats[0], 32'h0000_1000)
      `CHK(beats[$], 32'(32'h1000 + dl_t[i] + (sz_t[i] == 2'h3 ? 12 : 0)))
      rd(`P(OFS_SOURCE), v);
      `CHK(v, 32'(32'h1000 + 2 * dl_t[i]))
      rd(`P(OFS_COUNT), v);
      `CHK(v, 32'h0)
      `CHK(end_interrupt_q, i[0])
      `CHK(size_seen, (sz_t[i] == `P(SIZE_BLOCK)) ? `P(SIZE_LONG) : sz_t[i])
      `CHK(ack_seen, 1'b1)
      clear();
    end
    // early stops: master, nmi, address error, channel disable
    lat <= 4'h6;
    for (int k = 0; k < 4; k++) begin
      wr(`P(OFS_COUNT), 32'h0000_0003);
      wr(`P(OFS_CONTROL), ctl(`P(REQ_AUTO), 2'h2, 2'h1, 1'b1));
      wait_valid();
      if (k == 3) wr(`P(OFS_CONTROL), 32'h0);
      else begin
        @(posedge clk);
        master_enable <= (k != 0);
        nmi_flag <= (k == 1);
        addr_error <= (k == 2);
      end
      repeat (4) @(negedge clk);
      `CHK(xfer_valid_q, 1'b0)
      rd(`P(OFS_CONTROL), v);
      `CHK(v[1], 1'b0)
      rd(`P(OFS_COUNT), v);
      `CHK(v, 32'h0000_0003)
      wr(`P(OFS_CONTROL), 32'h0);
      @(posedge clk);
      master_enable <= 1'b1;
      nmi_flag <= 1'b0;
      addr_error <= 1'b0;
    end
    // peripheral source: one falling edge per unit
    lat <= 4'h1;
    beats.delete();
    wr(`P(OFS_COUNT), 32'h0000_0002);
    wr(`P(OFS_CONTROL), ctl(`P(REQ_PERIPH_FIRST), 2'h2, 2'h1, 1'b0));
    repeat (10) @(negedge clk);
    `CHK(beats.size(), 0)
    @(posedge clk);
    periph_req_n <= 6'h3E;
    repeat (20) @(negedge clk);
    `CHK(beats.size(), 1)
    repeat (2) @(posedge clk);
    periph_req_n <= 6'h3F;
    repeat (2) @(posedge clk);
    periph_req_n <= 6'h3E;
    wait_tend(v);
    `CHK(beats.size(), 2)
    @(posedge clk);
    periph_req_n <= 6'h3F;
    clear();
    // external pin, low-level sensing
    beats.delete();
    wr(`P(OFS_COUNT), 32'h0000_0001);
    wr(`P(OFS_CONTROL), ctl(`P(REQ_EXT_DUAL), 2'h2, 2'h1, 1'b0));
    repeat (10) @(negedge clk);
    `CHK(beats.size(), 0)
    @(posedge clk);
    pin_n <= 1'b0;
    wait_tend(v);
    `CHK(beats.size(), 1)
    @(posedge clk);
    pin_n <= 1'b1;
    clear();
    // external pin, falling edge: a held low level gives one unit only
    beats.delete();
    wr(`P(OFS_COUNT), 32'h0000_0002);
    wr(`P(OFS_CONTROL), ctl(`P(REQ_EXT_DUAL), 2'h2, 2'h1, 1'b0) | (32'h1 << `P(BIT_SENSE)));
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (20) @(negedge clk);
    `CHK(beats.size(), 1)
    @(posedge clk);
    pin_n <= 1'b1;
    repeat (3) @(posedge clk);
    pin_n <= 1'b0;
    wait_tend(v);
    `CHK(beats.size(), 2)
    `CHK(ack_seen, 1'b0)
    @(posedge clk);
    pin_n <= 1'b1;
    clear();
    // peripheral source in burst mode: one edge runs the whole count
    beats.delete();
    wr(`P(OFS_COUNT), 32'h0000_0002);
    wr(`P(OFS_CONTROL), ctl(4'(`P(REQ_PERIPH_FIRST) + 1), 2'h1, 2'h1, 1'b0) |
       (32'h1 << `P(BIT_BUS_MODE)));
    @(posedge clk);
    periph_req_n <= 6'h3D;
    wait_tend(v);
    `CHK(beats.size(), 2)
    `CHK(size_seen, `P(SIZE_WORD))
    @(posedge clk);
    periph_req_n <= 6'h3F;
    clear();
    print_verdict();
  end
endmodule
